/* File: common/ilc_pkg.sv */
/*
  Constants, register map and decode functions for the in-band loop code block.
  Assumes an 8-bit host port with byte addresses.
*/
`default_nettype none

package ilc_pkg;

  localparam logic [7:0] IBC_OFF      = 8'hb6;
  localparam logic [7:0] TXP1_OFF     = 8'hb7;
  localparam logic [7:0] TXP2_OFF     = 8'hb8;
  localparam logic [7:0] UP1_OFF      = 8'hb9;
  localparam logic [7:0] UP2_OFF      = 8'hba;
  localparam logic [7:0] DN1_OFF      = 8'hbb;
  localparam logic [7:0] DN2_OFF      = 8'hbc;
  localparam logic [7:0] SPC_OFF      = 8'hbd;
  localparam logic [7:0] SP1_OFF      = 8'hbe;
  localparam logic [7:0] SP2_OFF      = 8'hbf;
  localparam logic [7:0] STAT_OFF     = 8'hb4;

  localparam logic [7:0] REG_RST      = 8'h00;
  localparam logic [7:0] SPC_MASK     = 8'h07;
  localparam int         TXLEN_LSB    = 6;
  localparam int         UPLEN_LSB    = 3;
  localparam int         DNLEN_LSB    = 0;
  localparam int         SPLEN_LSB    = 0;

  localparam logic [1:0] TX_SEL_5     = 2'h0;
  localparam logic [1:0] TX_SEL_6     = 2'h1;
  localparam logic [1:0] TX_SEL_7     = 2'h2;
  localparam logic [4:0] TX_BITS_5    = 5'h05;
  localparam logic [4:0] TX_BITS_6    = 5'h06;
  localparam logic [4:0] TX_BITS_7    = 5'h07;
  localparam logic [4:0] BITS_WIDE    = 5'h10;
  localparam logic [2:0] RX_SEL_WIDE  = 3'h7;

  localparam int         FRAME_BITS   = 193;
  localparam int         INTEG_MS     = 36;
  localparam int         CLK_MHZ      = 200;
  localparam int         INTEG_CYC    = INTEG_MS * CLK_MHZ * 1000;
  localparam int         FIFO_DEPTH   = 8;

  typedef enum logic {ILC_TX_OFF, ILC_TX_RUN} ilc_tx_e;

  function automatic logic [4:0] ilc_tx_len(input logic [1:0] sel);
    case (sel)
      TX_SEL_5: ilc_tx_len = TX_BITS_5;
      TX_SEL_6: ilc_tx_len = TX_BITS_6;
      TX_SEL_7: ilc_tx_len = TX_BITS_7;
      default:  ilc_tx_len = BITS_WIDE;
    endcase
  endfunction

  function automatic logic [4:0] ilc_rx_len(input logic [2:0] sel);
    ilc_rx_len = (sel == RX_SEL_WIDE) ? BITS_WIDE : ({2'h0, sel} + 5'h01);
  endfunction

endpackage

`default_nettype wire

/* File: rtl/ilc_fifo.sv */
/*
  Small synchronous FIFO with registered full and empty flags.
  Assumes a single clock and a clock enable that freezes it.
*/
`timescale 1ns/10ps
`default_nettype none

module ilc_fifo import ilc_pkg::*; #(
  parameter int W     = 1,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic         cen_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output var  logic         in_ready_o,
  output var  logic [W-1:0] out_data_o,
  output var  logic         out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IX = (AW)'(DEPTH - 1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ix;
  logic [AW-1:0] rd_ix;
  logic [AW:0]   count;
  logic [AW:0]   next_count;
  logic          push;
  logic          pop;

  assign push = cen_i && in_valid_i && in_ready_o;
  assign pop  = cen_i && out_valid_o && out_ready_i;
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data_o = mem[rd_ix];

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ix] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_ix       <= '0;
      rd_ix       <= '0;
      count       <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end else if (cen_i) begin
      if (push) begin
        wr_ix <= (wr_ix == LAST_IX) ? '0 : wr_ix + 1'b1;
      end
      if (pop) begin
        rd_ix <= (rd_ix == LAST_IX) ? '0 : rd_ix + 1'b1;
      end
      count       <= next_count;
      in_ready_o  <= (next_count != FULL_CNT);
      out_valid_o <= (next_count != '0);
    end
  end

endmodule

`default_nettype wire

/* File: rtl/ilc_detector.sv */
/*
  One repeating-pattern detector with integration timer.
  Assumes one received bit per valid strobe, first pattern bit in code bit 15.
*/
`timescale 1ns/10ps
`default_nettype none

module ilc_detector import ilc_pkg::*; #(
  parameter int INTEG = INTEG_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        cen_i,
  input  wire logic        run_i,
  input  wire logic        bit_valid_i,
  input  wire logic        bit_i,
  input  wire logic [15:0] code_i,
  input  wire logic [4:0]  len_i,
  input  wire logic        restart_i,
  output var  logic        detected_o
);
  logic [15:0] hist;
  logic [4:0]  fill;
  logic [31:0] integ;
  logic        match;

  // All 16 history bits, oldest first, against every phase of the tiled code
  function automatic logic periodic_match(input logic [15:0] h, input logic [15:0] c,
                                          input logic [4:0] len);
    logic hit;
    logic ok;
    int   k;
    hit = 1'b0;
    for (int r = 0; r < 16; r++) begin
      ok = (r < int'(len));
      k  = r;
      for (int i = 0; i < 16; i++) begin
        if (ok && h[15-i] != c[15-k]) begin
          ok = 1'b0;
        end
        k = k + 1;
        if (k >= int'(len)) begin
          k = 0;
        end
      end
      hit = hit | ok;
    end
    periodic_match = hit;
  endfunction

  // [R19] every alignment tried; [R6] [R7] [R8] [R9] [R12] [R13] [R14] low bits unused
  assign match = (fill == BITS_WIDE) && periodic_match(hist, code_i, len_i);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hist <= '0;
    end else if (cen_i && run_i && bit_valid_i) begin
      hist <= {hist[14:0], bit_i};
    end
  end

  // [R5] restart clears fill
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      fill <= '0;
    end else if (cen_i) begin
      if (restart_i || !run_i) begin
        fill <= '0;
      end else if (bit_valid_i && fill != BITS_WIDE) begin
        fill <= fill + 5'h01;
      end
    end
  end

  // [R16] integrate continuous match
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      integ      <= '0;
      detected_o <= 1'b0;
    end else if (cen_i) begin
      if (restart_i || !run_i || !match) begin
        integ      <= '0;
        detected_o <= 1'b0;
      end else if (integ == 32'(INTEG - 1)) begin
        detected_o <= 1'b1;
      end else begin
        integ <= integ + 32'h1;
      end
    end
  end

  det_integ_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(detected_o) |-> $past(match) && integ == 32'(INTEG - 1)) // [R16]
    else $error("detect flag rose without full integration");

endmodule

`default_nettype wire

/* File: rtl/ilc_top.sv */
/*
  In-band loop code generator and three detectors with their registers.
  Assumes host strobes and line bits synchronous to clock_i.
*/
// Function
// [R1] Two-bit tx length: 5, 6/3, 7, 16/8/4/2/1
// [R2] Tx sends first-register bit 7 first
// [R3] Tx ignores low first-register bits for short lengths
// [R4] Second tx register is low byte, 16-bit only
// [R5] Writing detector first register restarts integration
// [R6] Up detector compares top L bits only
// [R7] Up detector ignores second register below 8
// [R8] Down detector compares top L bits only
// [R9] Down detector ignores second register below 8
// [R10] Spare length code 0-6 is 1-7, 7 wide
// [R11] Host writes zero to spare control upper bits
// [R12] Spare detector compares top L bits only
// [R13] Spare detector ignores second register below 8
// [R14] Detectors expect bit 7 first, descending
// [R15] Active only in T1 operation
// [R16] Flag set after 36 ms continuous match
// [R17] Two rx registers form one 16-bit code
// [R18] Repeat pattern, F-bit overwrites every 193rd
// [R19] Detectors match at any bit alignment
`timescale 1ns/10ps
`default_nettype none

module ilc_top import ilc_pkg::*; #(
  parameter int INTEG = INTEG_CYC,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       cen_i,
  input  wire logic       t1_mode_i,
  input  wire logic       tx_loop_code_enable_i,
  input  wire logic       fbit_insert_dis_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output var  logic [7:0] rdata_o,
  input  wire logic       tx_bit_req_i,
  input  wire logic       tx_fbit_i,
  output var  logic       tx_bit_o,
  output var  logic       tx_bit_valid_o,
  input  wire logic       rx_bit_i,
  input  wire logic       rx_bit_valid_i,
  output var  logic       rx_bit_ready_o,
  output var  logic       up_code_detected_flag_o,
  output var  logic       down_code_detected_flag_o,
  output var  logic       spare_code_detected_flag_o
);

  logic [7:0] inband_code_control;
  logic [7:0] tx_loop_pattern_first;
  logic [7:0] tx_loop_pattern_second;
  logic [7:0] rx_up_pattern_first;
  logic [7:0] rx_up_pattern_second;
  logic [7:0] rx_down_pattern_first;
  logic [7:0] rx_down_pattern_second;
  logic [7:0] spare_detector_control;
  logic [7:0] rx_spare_pattern_first;
  logic [7:0] rx_spare_pattern_second;

  logic       wr_en;
  logic       run;
  ilc_tx_e    tx_state;
  logic [3:0] tx_ix;
  logic [7:0] frame_pos;
  logic [4:0] tx_len;
  logic [15:0] tx_code;
  logic       tx_take;
  logic       fslot;
  logic       exp_first;

  logic        fifo_bit;
  logic        fifo_valid;
  logic [15:0] det_code    [3];
  logic [4:0]  det_len     [3];
  logic        det_restart [3];
  logic        det_flag    [3];

  assign wr_en = cen_i && wr_i;
  // [R15] T1 only
  assign run   = t1_mode_i;

  // Host register writes
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      inband_code_control     <= REG_RST;
      tx_loop_pattern_first   <= REG_RST;
      tx_loop_pattern_second  <= REG_RST;
      rx_up_pattern_first     <= REG_RST;
      rx_up_pattern_second    <= REG_RST;
      rx_down_pattern_first   <= REG_RST;
      rx_down_pattern_second  <= REG_RST;
      spare_detector_control  <= REG_RST;
      rx_spare_pattern_first  <= REG_RST;
      rx_spare_pattern_second <= REG_RST;
    end else if (wr_en) begin
      if (addr_i == IBC_OFF) begin
        inband_code_control <= wdata_i;
      end else if (addr_i == TXP1_OFF) begin
        tx_loop_pattern_first <= wdata_i;
      end else if (addr_i == TXP2_OFF) begin
        tx_loop_pattern_second <= wdata_i;
      end else if (addr_i == UP1_OFF) begin
        rx_up_pattern_first <= wdata_i;
      end else if (addr_i == UP2_OFF) begin
        rx_up_pattern_second <= wdata_i;
      end else if (addr_i == DN1_OFF) begin
        rx_down_pattern_first <= wdata_i;
      end else if (addr_i == DN2_OFF) begin
        rx_down_pattern_second <= wdata_i;
      end else if (addr_i == SPC_OFF) begin
        // [R11] upper bits kept at zero
        spare_detector_control <= wdata_i & SPC_MASK;
      end else if (addr_i == SP1_OFF) begin
        rx_spare_pattern_first <= wdata_i;
      end else if (addr_i == SP2_OFF) begin
        rx_spare_pattern_second <= wdata_i;
      end
    end
  end

  // Host register reads, unmapped reads as zero
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= REG_RST;
    end else if (cen_i && rd_i) begin
      if (addr_i == IBC_OFF) begin
        rdata_o <= inband_code_control;
      end else if (addr_i == TXP1_OFF) begin
        rdata_o <= tx_loop_pattern_first;
      end else if (addr_i == TXP2_OFF) begin
        rdata_o <= tx_loop_pattern_second;
      end else if (addr_i == UP1_OFF) begin
        rdata_o <= rx_up_pattern_first;
      end else if (addr_i == UP2_OFF) begin
        rdata_o <= rx_up_pattern_second;
      end else if (addr_i == DN1_OFF) begin
        rdata_o <= rx_down_pattern_first;
      end else if (addr_i == DN2_OFF) begin
        rdata_o <= rx_down_pattern_second;
      end else if (addr_i == SPC_OFF) begin
        rdata_o <= spare_detector_control;
      end else if (addr_i == SP1_OFF) begin
        rdata_o <= rx_spare_pattern_first;
      end else if (addr_i == SP2_OFF) begin
        rdata_o <= rx_spare_pattern_second;
      end else if (addr_i == STAT_OFF) begin
        rdata_o <= {5'h00, det_flag[2], det_flag[1], det_flag[0]};
      end else begin
        rdata_o <= REG_RST;
      end
    end
  end

  // [R1] tx length decode
  assign tx_len    = ilc_tx_len(inband_code_control[TXLEN_LSB +: 2]);
  // [R4] second register is the low byte
  assign tx_code   = {tx_loop_pattern_first, tx_loop_pattern_second};
  assign tx_take   = (tx_state == ILC_TX_RUN) && run && tx_loop_code_enable_i && tx_bit_req_i;
  assign fslot     = (frame_pos == 8'h00) && !fbit_insert_dis_i;
  assign exp_first = tx_loop_pattern_first[3'h7 - tx_ix[2:0]];

  // Transmit generator
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tx_state       <= ILC_TX_OFF;
      tx_ix          <= '0;
      frame_pos      <= '0;
      tx_bit_o       <= 1'b0;
      tx_bit_valid_o <= 1'b0;
    end else if (cen_i) begin
      tx_bit_valid_o <= 1'b0;
      case (tx_state)
        ILC_TX_OFF: begin
          if (run && tx_loop_code_enable_i) begin
            tx_state  <= ILC_TX_RUN;
            tx_ix     <= '0;
            frame_pos <= '0;
          end
        end
        ILC_TX_RUN: begin
          if (!(run && tx_loop_code_enable_i)) begin
            tx_state <= ILC_TX_OFF;
          end else if (tx_bit_req_i) begin
            tx_bit_valid_o <= 1'b1;
            // [R18] F-bit overwrites, pattern keeps running
            // [R2] [R3] bit 7 first, only len bits used
            tx_bit_o <= fslot ? tx_fbit_i : tx_code[4'hf - tx_ix];
            tx_ix    <= ({1'b0, tx_ix} == tx_len - 5'h01) ? 4'h0 : tx_ix + 4'h1;
            frame_pos <= (frame_pos == 8'(FRAME_BITS - 1)) ? 8'h00 : frame_pos + 8'h01;
          end
        end
        default: begin
          tx_state <= ILC_TX_OFF;
        end
      endcase
    end
  end

  // Receive bits buffered ahead of the detectors; stalls outside T1
  ilc_fifo #(
    .W     (1),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .cen_i       (cen_i),
    .in_data_i   (rx_bit_i),
    .in_valid_i  (rx_bit_valid_i),
    .in_ready_o  (rx_bit_ready_o),
    .out_data_o  (fifo_bit),
    .out_valid_o (fifo_valid),
    .out_ready_i (run)
  );

  // [R17] both rx registers form one code; [R10] spare length
  assign det_code[0] = {rx_up_pattern_first, rx_up_pattern_second};
  assign det_code[1] = {rx_down_pattern_first, rx_down_pattern_second};
  assign det_code[2] = {rx_spare_pattern_first, rx_spare_pattern_second};
  assign det_len[0]  = ilc_rx_len(inband_code_control[UPLEN_LSB +: 3]);
  assign det_len[1]  = ilc_rx_len(inband_code_control[DNLEN_LSB +: 3]);
  assign det_len[2]  = ilc_rx_len(spare_detector_control[SPLEN_LSB +: 3]);
  // [R5] first-register write restarts
  assign det_restart[0] = wr_en && addr_i == UP1_OFF;
  assign det_restart[1] = wr_en && addr_i == DN1_OFF;
  assign det_restart[2] = wr_en && addr_i == SP1_OFF;

  generate
    for (genvar d = 0; d < 3; d++) begin : g_det
      ilc_detector #(
        .INTEG (INTEG)
      ) u_det (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .cen_i       (cen_i),
        .run_i       (run),
        .bit_valid_i (fifo_valid),
        .bit_i       (fifo_bit),
        .code_i      (det_code[d]),
        .len_i       (det_len[d]),
        .restart_i   (det_restart[d]),
        .detected_o  (det_flag[d])
      );
    end
  endgenerate

  assign up_code_detected_flag_o    = det_flag[0];
  assign down_code_detected_flag_o  = det_flag[1];
  assign spare_code_detected_flag_o = det_flag[2];

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  tx_first_bit_a: assert property (
    cen_i && tx_take && tx_ix == 4'h0 && !fslot |=> tx_bit_o == $past(tx_loop_pattern_first[7])) // [R2]
    else $error("first pattern bit not from bit 7");

  tx_len_wrap_a: assert property (
    tx_state == ILC_TX_RUN |-> {1'b0, tx_ix} < tx_len) // [R1]
    else $error("tx index beyond selected length");

  tx_short_bits_a: assert property (
    cen_i && tx_take && !fslot && tx_len != BITS_WIDE |=> tx_bit_o == $past(exp_first)) // [R3]
    else $error("short pattern used a don't care bit");

  tx_low_byte_a: assert property (
    cen_i && tx_take && !fslot && tx_ix[3] |=> tx_bit_o == $past(tx_loop_pattern_second[7])
      || !$past(tx_ix == 4'h8)) // [R4]
    else $error("second register not sent as low byte");

  fbit_insert_a: assert property (
    cen_i && tx_take && fslot |=> tx_bit_valid_o && tx_bit_o == $past(tx_fbit_i)) // [R18]
    else $error("F-bit not placed in frame slot");

  frame_count_a: assert property (
    int'(frame_pos) < FRAME_BITS) // [R18]
    else $error("frame position out of range");

  e1_quiet_a: assert property (
    cen_i && !t1_mode_i |=> !tx_bit_valid_o ##1 !up_code_detected_flag_o) // [R15]
    else $error("loop code active outside T1");

  up_restart_a: assert property (
    det_restart[0] |=> !up_code_detected_flag_o) // [R5]
    else $error("up detector flag survived a restart");

  spare_upper_a: assert property (
    spare_detector_control[7:3] == 5'h00) // [R11]
    else $error("spare control upper bits not zero");

  dn_restart_a: assert property (
    det_restart[1] |=> !down_code_detected_flag_o) // [R5]
    else $error("down detector flag survived a restart");

  sp_restart_a: assert property (
    det_restart[2] |=> !spare_code_detected_flag_o) // [R5]
    else $error("spare detector flag survived a restart");

  e1_flags_a: assert property (
    cen_i && !t1_mode_i |=> !down_code_detected_flag_o && !spare_code_detected_flag_o) // [R15]
    else $error("detector flag set outside T1");

  tx_answer_a: assert property (
    cen_i && tx_take |=> tx_bit_valid_o) // [R18]
    else $error("tx request got no bit");

  tx_silent_a: assert property (
    cen_i && !tx_take |=> !tx_bit_valid_o) // [R18]
    else $error("tx bit without a request");

  tx_repeat_a: assert property (
    cen_i && tx_take && {1'b0, tx_ix} == tx_len - 5'h01 |=> tx_ix == 4'h0) // [R1]
    else $error("pattern did not restart at its first bit");

  tx_wide_len_a: assert property (
    inband_code_control[7:6] == 2'h3 |-> tx_len == BITS_WIDE) // [R1]
    else $error("wide tx length not selected");

  frame_wrap_a: assert property (
    cen_i && tx_take && int'(frame_pos) == FRAME_BITS - 1 |=> frame_pos == 8'h00) // [R18]
    else $error("frame position did not wrap");

  sp_len_wide_a: assert property (
    spare_detector_control[2:0] == RX_SEL_WIDE |-> det_len[2] == BITS_WIDE) // [R10]
    else $error("spare wide length not selected");

  sp_len_short_a: assert property (
    spare_detector_control[2:0] != RX_SEL_WIDE |-> det_len[2] != 5'h00 && det_len[2] <= 5'h07) // [R10]
    else $error("spare short length out of range");

  stat_flags_a: assert property (
    cen_i && rd_i && addr_i == STAT_OFF |=> rdata_o[2:0] ==
      $past({spare_code_detected_flag_o, down_code_detected_flag_o, up_code_detected_flag_o})) // [R16]
    else $error("status read does not show the flags");

endmodule

`default_nettype wire

/* File: tb/ilc_line_model.sv */
/*
  Far-end line model: sends a repeating loop code into the receive path.
  Assumes the bench changes send_i and the code only at the falling edge.
*/
`timescale 1ns/10ps
`default_nettype none

module ilc_line_model (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        cen_i,
  input  wire logic        send_i,
  input  wire logic [15:0] code_i,
  input  wire logic [4:0]  len_i,
  input  wire logic        ready_i,
  output var  logic        rx_bit_o,
  output var  logic        rx_valid_o
);
  logic [4:0] idx;
  logic       send_q;

  always_ff @(posedge clock_i) begin
    send_q <= send_i & ~rst_i;
    if (rst_i || !send_i) begin
      idx <= 5'h00;
    end else if (rx_valid_o && ready_i && cen_i) begin
      idx <= (idx + 5'h01 == len_i) ? 5'h00 : idx + 5'h01;
    end
  end

  // Idle line keeps toggling so no stale bit looks valid
  always_ff @(negedge clock_i) begin
    if (rst_i) begin
      rx_valid_o <= 1'b0;
      rx_bit_o   <= 1'b0;
    end else begin
      rx_valid_o <= send_q;
      rx_bit_o   <= send_q ? code_i[4'hf - idx[3:0]] : ~rx_bit_o;
    end
  end
endmodule

`default_nettype wire

/* File: tb/test_inband_loop_code_gen_detect.sv */
/*
  Self-checking bench for the in-band loop code block.
  Assumes a 200 MHz clock, synchronous reset and a short integration count.
*/
`timescale 1ns/10ps
`default_nettype none

module test_inband_loop_code_gen_detect import ilc_pkg::*; ;
  localparam int INTEG_T = 20;
  localparam int NROWS   = 8;
  typedef struct packed {
    logic [1:0]  sel;
    logic [2:0]  lcode;
    logic [7:0]  first;
    logic [7:0]  second;
    logic [15:0] pat;
    logic [4:0]  plen;
    logic        exp;
  } ilc_row_s;
  // Detector select, length code, registers, sent code, sent length, expected flag
  localparam ilc_row_s ROWS [NROWS] = '{
    '{2'h0, 3'h2, 8'ha5, 8'h3c, 16'ha000, 5'h03, 1'b1},
    '{2'h0, 3'h4, 8'h80, 8'hff, 16'h8800, 5'h05, 1'b0},
    '{2'h0, 3'h7, 8'h56, 8'h56, 16'h5656, 5'h10, 1'b1},
    '{2'h1, 3'h6, 8'hd0, 8'h55, 16'h1a00, 5'h07, 1'b1},
    '{2'h1, 3'h6, 8'hd1, 8'h00, 16'h1600, 5'h07, 1'b0},
    '{2'h2, 3'h0, 8'h80, 8'h77, 16'h8000, 5'h01, 1'b1},
    '{2'h2, 3'h7, 8'h12, 8'h35, 16'h1234, 5'h10, 1'b0},
    '{2'h2, 3'h7, 8'h12, 8'h34, 16'h1234, 5'h10, 1'b1}
  };
  localparam logic [7:0]  A1 [3]    = '{UP1_OFF, DN1_OFF, SP1_OFF};
  localparam logic [7:0]  A2 [3]    = '{UP2_OFF, DN2_OFF, SP2_OFF};
  localparam logic [7:0]  REGS [11] = '{IBC_OFF, TXP1_OFF, TXP2_OFF, UP1_OFF, UP2_OFF, DN1_OFF, DN2_OFF,
                                        SPC_OFF, SP1_OFF, SP2_OFF, STAT_OFF};
  localparam logic [1:0]  TSEL [5]  = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
  localparam logic        TDIS [5]  = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  localparam int          TN [5]    = '{20, 20, 20, 200, 20};
  localparam int          TLEN [5]  = '{5, 6, 7, 16, 16};
  localparam logic [15:0] TXPAT     = 16'ha75a;

  logic        clock_i = 1'b0;
  logic        rst_i   = 1'b1;
  logic        cen     = 1'b1;
  logic        t1      = 1'b1;
  logic        tx_en   = 1'b0;
  logic        fdis    = 1'b0;
  logic        req     = 1'b0;
  logic        fbit    = 1'b0;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        send    = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic [7:0]  wdata   = 8'h00;
  logic [15:0] pat     = 16'h0000;
  logic [4:0]  plen    = 5'h01;
  logic [7:0]  d, v, ibc;
  logic        exp_b, any;
  int          n, k;
  int          err_total = 0;
  int          tests_run = 0;
  wire  logic  [7:0] rdata;
  wire  logic  tx_bit, tx_v, rx_bit, rx_v, ready;
  wire  logic  [2:0] flag;

  always #2.5 clock_i = ~clock_i;

  ilc_top #(.INTEG(INTEG_T), .DEPTH(FIFO_DEPTH)) ilc_top_i (
    .clock_i(clock_i), .rst_i(rst_i), .cen_i(cen), .t1_mode_i(t1), .tx_loop_code_enable_i(tx_en),
    .fbit_insert_dis_i(fdis), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .tx_bit_req_i(req), .tx_fbit_i(fbit), .tx_bit_o(tx_bit), .tx_bit_valid_o(tx_v),
    .rx_bit_i(rx_bit), .rx_bit_valid_i(rx_v), .rx_bit_ready_o(ready),
    .up_code_detected_flag_o(flag[0]), .down_code_detected_flag_o(flag[1]),
    .spare_code_detected_flag_o(flag[2])
  );

  ilc_line_model ilc_line_model_i (
    .clock_i(clock_i), .rst_i(rst_i), .cen_i(cen), .send_i(send), .code_i(pat), .len_i(plen),
    .ready_i(ready), .rx_bit_o(rx_bit), .rx_valid_o(rx_v)
  );

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] dat);
    @(negedge clock_i);
    addr  = a;
    wdata = dat;
    wr    = 1'b1;
    @(negedge clock_i);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] dat);
    @(negedge clock_i);
    addr = a;
    rd   = 1'b1;
    @(negedge clock_i);
    rd = 1'b0;
    @(negedge clock_i);
    dat = rdata;
  endtask

  task automatic wait_flag(input int s, output int cnt);
    cnt = 0;
    while (flag[s] !== 1'b1 && cnt < 200) begin
      @(negedge clock_i);
      cnt++;
    end
  endtask

  initial begin
    ibc = 8'h00;
    repeat (16) @(negedge clock_i);
    rst_i = 1'b0;
    for (int i = 0; i < NROWS; i++) begin
      send = 1'b0;
      repeat (12) @(negedge clock_i);
      if (ROWS[i].sel == 2'h2) begin
        wr_reg(SPC_OFF, {5'h00, ROWS[i].lcode});
      end else begin
        if (ROWS[i].sel == 2'h0) ibc[5:3] = ROWS[i].lcode;
        else ibc[2:0] = ROWS[i].lcode;
        wr_reg(IBC_OFF, ibc);
      end
      wr_reg(A2[ROWS[i].sel], ROWS[i].second);
      wr_reg(A1[ROWS[i].sel], ROWS[i].first);
      pat  = ROWS[i].pat;
      plen = ROWS[i].plen;
      send = 1'b1;
      wait_flag(int'(ROWS[i].sel), n);
      check("detect flag", 8'(flag[ROWS[i].sel]), 8'(ROWS[i].exp));
      if (ROWS[i].exp) begin
        check("integration time", 8'(n > INTEG_T + 8), 8'h01);
        wr_reg(A1[ROWS[i].sel], ROWS[i].first);
        repeat (2) @(negedge clock_i);
        check("restart flag", 8'(flag[ROWS[i].sel]), 8'h00);
      end
    end
    // Fill the receive buffer while E1 stalls the detectors
    wait_flag(2, n);
    check("spare flag", 8'(flag[2]), 8'h01);
    t1 = 1'b0;
    repeat (3) @(negedge clock_i);
    check("e1 flag", 8'(flag[2]), 8'h00);
    repeat (20) @(negedge clock_i);
    check("buffer full", 8'(ready), 8'h00);
    send = 1'b0;
    t1   = 1'b1;
    repeat (12) @(negedge clock_i);
    check("buffer drained", 8'(ready), 8'h01);
    wr_reg(TXP1_OFF, TXPAT[15:8]);
    wr_reg(TXP2_OFF, TXPAT[7:0]);
    for (int j = 0; j < 5; j++) begin
      tx_en = 1'b0;
      fdis  = TDIS[j];
      fbit  = TSEL[j][0];
      wr_reg(IBC_OFF, {TSEL[j], 6'h00});
      tx_en = 1'b1;
      repeat (2) @(negedge clock_i);
      req = 1'b1;
      k   = 0;
      n   = 0;
      while (k < TN[j] && n < 400) begin
        @(posedge clock_i);
        #1;
        n++;
        if (tx_v === 1'b1) begin
          exp_b = (k % FRAME_BITS == 0 && !TDIS[j]) ? fbit : TXPAT[15 - (k % TLEN[j])];
          check("tx bit", 8'(tx_bit), 8'(exp_b));
          k++;
        end
      end
      @(negedge clock_i);
      req = 1'b0;
      if (k < TN[j]) begin
        err_total++;
        $display("[ERR] tx bits expected %0d seen %0d", TN[j], k);
        print_verdict();
      end
    end
    t1  = 1'b0;
    req = 1'b1;
    any = 1'b0;
    repeat (10) begin
      @(posedge clock_i);
      #1;
      any = any | tx_v;
    end
    check("e1 tx valid", 8'(any), 8'h00);
    @(negedge clock_i);
    req   = 1'b0;
    tx_en = 1'b0;
    t1    = 1'b1;
    rst_i = 1'b1;
    repeat (4) @(negedge clock_i);
    rst_i = 1'b0;
    for (int i = 0; i < 11; i++) begin
      rd_reg(REGS[i], d);
      check("reset value", d, REG_RST);
    end
    for (int i = 0; i < 10; i++) begin
      v = (REGS[i] == SPC_OFF) ? 8'h05 : 8'h3c + 8'(i);
      wr_reg(REGS[i], v);
      rd_reg(REGS[i], d);
      check("read back", d, v);
    end
    cen = 1'b0;
    wr_reg(TXP1_OFF, 8'hff);
    cen = 1'b1;
    rd_reg(TXP1_OFF, d);
    check("frozen write", d, 8'h3d);
    wr_reg(8'hc0, 8'hff);
    rd_reg(8'hc0, d);
    check("unmapped read", d, 8'h00);
    print_verdict();
  end
endmodule

`default_nettype wire
